// >>> dnc_consts.svh
// Purpose: Constants for the channel binding and oscillator sync control block
// Assumes: Byte-wide register port with a 10-bit address
// Notes: Offsets are byte addresses of the register port
`ifndef DNC_CONSTS_SVH
`define DNC_CONSTS_SVH

`define DNC_ADDR_W 10
`define DNC_OFS_BIND 10'h216
`define DNC_OFS_RDIV_LO 10'h217
`define DNC_OFS_RDIV_HI 10'h218
`define DNC_OFS_SYNC 10'h219
`define DNC_RST_BIND 8'h02
`define DNC_RST_RDIV 16'h0000
`define DNC_RST_SYNC 8'h02
`define DNC_BIT_SEL_A 0
`define DNC_BIT_SEL_B 1
`define DNC_BIT_ARM 0
`define DNC_BIT_ILA 1
`define DNC_PHASE_SHIFT 16

`endif

// >>> dnc_ctrl.sv
// What this block does
// R1: Bit 1 selects source of digital channel B
// R2: Bit 0 selects source of digital channel A
// R3: Single-channel mode needs default binding
// R4: Software disables link and calibration first
// R5: Digital channel follows bound converter powerdown
// R6: Sixteen-bit divisor shared by all presets
// R7: Link-start sync bit inits phase at ILA
// R8: Arm by writing 0 then 1; next edge inits
// R9: After one init, ignore edges until rearmed
// R10: Controller prepares devices, SYSREF quiet first
// R11: Controller clears link sync, arms, pulses SYSREF
// R12: Phase offset placed in upper accumulator bits
//
// Purpose: Control registers for channel routing and oscillator phase sync
// Assumes: Byte register port, read data valid the cycle after the strobe
// Notes: Unmapped reads return zero, unmapped writes are dropped
//        Reserved bits are stored and read back as written
//        Binding changes act at once, with no interlock against link or calibration
//        A 0 written to the arm bit in the cycle of the firing edge still counts
//        R3, R4, R10 and R11 are the controller's duty and have no logic here
`timescale 1ns/1ps
`include "dnc_consts.svh"

module dnc_ctrl
    import dnc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [`DNC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic conv_a_powerdown,
    input wire logic conv_b_powerdown,
    input wire logic sysref,
    input wire logic lmfc_ila_start,
    input wire logic [15:0] phase_offset,
    output logic chan_a_source_sel,
    output logic chan_b_source_sel,
    output logic chan_a_powerdown,
    output logic chan_b_powerdown,
    output logic [15:0] rational_divisor,
    output logic phase_init,
    output logic sync_armed,
    output logic [31:0] phase_offset_word
);

    // Register file, arm state and pipeline state
    dnc_req_type req;
    dnc_pd_type pd;
    dnc_arm_type arm_q;
    dnc_arm_type arm_d;
    logic [7:0] bind_q;
    logic [7:0] bind_d;
    logic [15:0] rdiv_q;
    logic [15:0] rdiv_d;
    logic [7:0] sync_q;
    logic [7:0] sync_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic init_q;
    logic init_d;
    logic [31:0] poff_q;
    logic [31:0] poff_d;
    logic sysref_rise;
    logic sync_wr;

    // Address decode shared by the write and read paths
    function automatic logic hit(input logic [`DNC_ADDR_W-1:0] a, input logic [`DNC_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    // One strobe feeds both the sync register and the arm sequence
    assign sync_wr = req.wr && hit(req.addr, `DNC_OFS_SYNC);

    // SYSREF is taken as already synchronous; only its rising edge is used
    dnc_edge_det u_edge (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .level_in(sysref),
        .rise_pulse(sysref_rise)
    );

    // Register writes; all bits are kept, reserved ones included
    always_comb begin
        bind_d = bind_q;
        rdiv_d = rdiv_q;
        sync_d = sync_q;
        if (req.wr) begin
            if (hit(req.addr, `DNC_OFS_BIND)) begin
                bind_d = req.wdata; // R1 R2
            end
            // Divisor bytes land one at a time; a half-written value is live meanwhile
            if (hit(req.addr, `DNC_OFS_RDIV_LO)) begin
                rdiv_d[7:0] = req.wdata; // R6
            end
            if (hit(req.addr, `DNC_OFS_RDIV_HI)) begin
                rdiv_d[15:8] = req.wdata; // R6
            end
            if (sync_wr) begin
                sync_d = req.wdata;
            end
        end
    end

    // Reset values give the default routing and link-start sync
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bind_q <= `DNC_RST_BIND;
            rdiv_q <= `DNC_RST_RDIV;
            sync_q <= `DNC_RST_SYNC;
        end else begin
            bind_q <= bind_d;
            rdiv_q <= rdiv_d;
            sync_q <= sync_d;
        end
    end

    // Arm sequence: a written 0 then a written 1, one shot per arming
    always_comb begin
        arm_d = arm_q;
        case (arm_q)
            DNC_IDLE: begin
                if (sync_wr && !req.wdata[`DNC_BIT_ARM]) begin
                    arm_d = DNC_ZERO_SEEN; // R8
                end
            end
            DNC_ZERO_SEEN: begin
                if (sync_wr && req.wdata[`DNC_BIT_ARM]) begin
                    arm_d = DNC_ARMED; // R8
                end
            end
            DNC_ARMED: begin
                // The edge fires and disarms; a 0 written in that cycle still counts toward rearming
                if (sysref_rise && sync_wr && !req.wdata[`DNC_BIT_ARM]) begin
                    arm_d = DNC_ZERO_SEEN; // R9
                end else if (sysref_rise) begin
                    arm_d = DNC_IDLE; // R9
                end else if (sync_wr && !req.wdata[`DNC_BIT_ARM]) begin
                    arm_d = DNC_ZERO_SEEN; // R8
                end
            end
            default: begin
                arm_d = DNC_IDLE;
            end
        endcase
    end

    // Arm state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_q <= DNC_IDLE;
        end else begin
            arm_q <= arm_d;
        end
    end

    // Phase init pulse and offset word; the link-start source is gated by its bit
    always_comb begin
        init_d = (arm_q == DNC_ARMED) && sysref_rise; // R8 R9
        if (sync_q[`DNC_BIT_ILA] && lmfc_ila_start) begin
            init_d = 1'b1; // R7
        end
        // Offset sits in the top half so it adds at full accumulator weight
        poff_d = {phase_offset, {`DNC_PHASE_SHIFT{1'b0}}}; // R12
    end

    // Registered so the init pulse is one clean cycle wide
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            init_q <= 1'b0;
            poff_q <= 32'h0000_0000;
        end else begin
            init_q <= init_d;
            poff_q <= poff_d;
        end
    end

    // Read mux; data appear the cycle after the strobe, zero when unmapped
    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            if (hit(req.addr, `DNC_OFS_BIND)) begin
                rdata_d = bind_q;
            end else if (hit(req.addr, `DNC_OFS_RDIV_LO)) begin
                rdata_d = rdiv_q[7:0];
            end else if (hit(req.addr, `DNC_OFS_RDIV_HI)) begin
                rdata_d = rdiv_q[15:8];
            end else if (hit(req.addr, `DNC_OFS_SYNC)) begin
                rdata_d = sync_q;
            end
        end
    end

    // Fixed one-cycle answer; the port never inserts wait states
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // A digital channel is down when the converter it is bound to is down
    // Kept combinational so a converter powerdown reaches its channel with no lag
    always_comb begin
        pd.chan_a_pd = bind_q[`DNC_BIT_SEL_A] ? conv_b_powerdown : conv_a_powerdown; // R5
        pd.chan_b_pd = bind_q[`DNC_BIT_SEL_B] ? conv_b_powerdown : conv_a_powerdown; // R5
    end

    // Data outputs come straight from registers; powerdown and the sync_armed state decode are combinational
    // Binding is used live; software must quiesce link and calibration first
    assign chan_a_source_sel = bind_q[`DNC_BIT_SEL_A]; // R2 R4
    assign chan_b_source_sel = bind_q[`DNC_BIT_SEL_B]; // R1
    assign chan_a_powerdown = pd.chan_a_pd;
    assign chan_b_powerdown = pd.chan_b_pd;
    assign rational_divisor = rdiv_q;
    assign phase_init = init_q;
    assign sync_armed = (arm_q == DNC_ARMED);
    assign phase_offset_word = poff_q;
    assign reg_rdata = rdata_q;

endmodule

// >>> dnc_ctrl_checker.sv
// Purpose: Port-level checker for dnc_ctrl
// Assumes: One clock domain, reset async active low
// Notes: Ports mirror the top module, one to a line
`timescale 1ns/1ps
`include "dnc_consts.svh"
module dnc_ctrl_checker(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [`DNC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic conv_a_powerdown,
    input wire logic conv_b_powerdown,
    input wire logic sysref,
    input wire logic lmfc_ila_start,
    input wire logic [15:0] phase_offset,
    input wire logic chan_a_source_sel,
    input wire logic chan_b_source_sel,
    input wire logic chan_a_powerdown,
    input wire logic chan_b_powerdown,
    input wire logic [15:0] rational_divisor,
    input wire logic phase_init,
    input wire logic sync_armed,
    input wire logic [31:0] phase_offset_word
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Routing, powerdown and divisor follow the register port
    a_sel_follow_write: assert property (reg_wr && reg_addr == `DNC_OFS_BIND |=>
        {chan_b_source_sel, chan_a_source_sel} == $past(reg_wdata[1:0])) else $error("binding not taken");
    a_pd_a_bound: assert property (chan_a_powerdown == (chan_a_source_sel ? conv_b_powerdown : conv_a_powerdown))
        else $error("channel a powerdown wrong");
    a_pd_b_bound: assert property (chan_b_powerdown == (chan_b_source_sel ? conv_b_powerdown : conv_a_powerdown))
        else $error("channel b powerdown wrong");
    a_div_low_byte: assert property (reg_wr && reg_addr == `DNC_OFS_RDIV_LO |=>
        rational_divisor[7:0] == $past(reg_wdata)) else $error("divisor low byte not taken");
    // Phase init only from a link start or an armed edge, and disarms
    a_sysref_fire: assert property (sync_armed && sysref && !$past(sysref) |=> phase_init && !sync_armed)
        else $error("armed edge missed");
    a_init_cause: assert property (phase_init |-> $past(lmfc_ila_start) || ($past(sync_armed) && $past(sysref)))
        else $error("phase init without cause");
    a_arm_by_write: assert property ($rose(sync_armed) |-> $past(reg_wr) && $past(reg_wdata[0]))
        else $error("armed without write");
    a_offset_msb: assert property ($past(rst_b) |-> phase_offset_word == {$past(phase_offset), 16'h0000})
        else $error("offset word wrong");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
    c_sysref_init: cover property (phase_init && $past(sysref));
    c_ila_init: cover property (phase_init && $past(lmfc_ila_start));
    c_armed: cover property ($rose(sync_armed));
endmodule
bind dnc_ctrl dnc_ctrl_checker chk(
    .core_clk(core_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_a_powerdown(conv_a_powerdown),
    .conv_b_powerdown(conv_b_powerdown),
    .sysref(sysref),
    .lmfc_ila_start(lmfc_ila_start),
    .phase_offset(phase_offset),
    .chan_a_source_sel(chan_a_source_sel),
    .chan_b_source_sel(chan_b_source_sel),
    .chan_a_powerdown(chan_a_powerdown),
    .chan_b_powerdown(chan_b_powerdown),
    .rational_divisor(rational_divisor),
    .phase_init(phase_init),
    .sync_armed(sync_armed),
    .phase_offset_word(phase_offset_word)
);

// >>> dnc_ctrl_test.sv
// Purpose: Self-checking bench for dnc_ctrl
// Assumes: Peer model drives SYSREF and link start
// Notes: Model tracks registers and arm state
`timescale 1ns/1ps
`include "dnc_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module dnc_ctrl_test;
    logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sref_go = 1'b0, ila_go = 1'b0;
    logic conv_a_powerdown = 1'b0, conv_b_powerdown = 1'b0, sysref, lmfc_ila_start, phase_init, sync_armed;
    logic chan_a_source_sel, chan_b_source_sel, chan_a_powerdown, chan_b_powerdown;
    logic [`DNC_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, m_sync = 8'h02;
    logic [3:0] sref_len = 4'h1;
    logic [15:0] phase_offset = 16'h0000, rational_divisor, m_rdiv = 16'h0000;
    logic [31:0] phase_offset_word, seed = 32'hf4d7d4fc, r;
    int miscompares = 0, comparisons = 0, m_arm = 0, n;
    dnc_ctrl dut(
        .core_clk(core_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .conv_a_powerdown(conv_a_powerdown),
        .conv_b_powerdown(conv_b_powerdown),
        .sysref(sysref),
        .lmfc_ila_start(lmfc_ila_start),
        .phase_offset(phase_offset),
        .chan_a_source_sel(chan_a_source_sel),
        .chan_b_source_sel(chan_b_source_sel),
        .chan_a_powerdown(chan_a_powerdown),
        .chan_b_powerdown(chan_b_powerdown),
        .rational_divisor(rational_divisor),
        .phase_init(phase_init),
        .sync_armed(sync_armed),
        .phase_offset_word(phase_offset_word)
    );
    dnc_link_peer peer(
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sref_go(sref_go),
        .sref_len(sref_len),
        .ila_go(ila_go),
        .sysref(sysref),
        .lmfc_ila_start(lmfc_ila_start)
    );
    always #25 core_clk = ~core_clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr(input logic [`DNC_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [`DNC_ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // Arm needs a 0 write then a 1 write
    task automatic sync_w(input logic [7:0] d);
        wr(`DNC_OFS_SYNC, d);
        m_sync = d;
        m_arm = !d[0] ? 1 : (m_arm == 1 ? 2 : m_arm);
        `CHK(sync_armed, m_arm == 2)
    endtask
    // Count phase init pulses over a fixed window after one stimulus
    task automatic fire(input logic s);
        @(posedge core_clk);
        sref_go <= s;
        ila_go <= !s;
        sref_len <= 4'(xs() % 3 + 1);
        @(posedge core_clk);
        sref_go <= 1'b0;
        ila_go <= 1'b0;
        n = 0;
        repeat (6) begin
            @(posedge core_clk);
            #1 n += int'(phase_init);
        end
        `CHK(n, int'(s ? m_arm == 2 : m_sync[1]))
        // Only an edge that actually fired disarms; a zero-seen state survives a stray edge
        if (s && m_arm == 2) m_arm = 0;
        `CHK(sync_armed, m_arm == 2)
    endtask
    task automatic tally_and_finish();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        $display("unexpected at %0t watchdog", $time);
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`DNC_OFS_BIND, 8'h02);
        rd(`DNC_OFS_RDIV_LO, 8'h00);
        rd(`DNC_OFS_RDIV_HI, 8'h00);
        rd(`DNC_OFS_SYNC, 8'h02);
        rd(10'h215, 8'h00);
        $display("test reset done");
        repeat (16) begin
            r = xs();
            wr(`DNC_OFS_BIND, r[7:0]); // dual-channel mode and an idle link are assumed here
            wr(`DNC_OFS_RDIV_LO + r[8], r[23:16]);
            m_rdiv[8*r[8] +: 8] = r[23:16];
            @(posedge core_clk);
            conv_a_powerdown <= r[9];
            conv_b_powerdown <= r[10];
            phase_offset <= r[31:16];
            @(posedge core_clk);
            #1 `CHK({chan_b_source_sel, chan_a_source_sel}, r[1:0])
            `CHK(chan_a_powerdown, r[0] ? r[10] : r[9])
            `CHK(chan_b_powerdown, r[1] ? r[10] : r[9])
            `CHK(rational_divisor, m_rdiv)
            `CHK(phase_offset_word, {r[31:16], 16'h0000})
            rd(`DNC_OFS_BIND, r[7:0]);
        end
        $display("test binding done");
        sync_w(8'h03);
        fire(1'b0);
        sync_w(8'h00);
        fire(1'b0);
        fire(1'b1);
        sync_w(8'h01);
        fire(1'b1);
        fire(1'b1);
        sync_w(8'h00);
        sync_w(8'h01);
        fire(1'b1);
        rd(`DNC_OFS_SYNC, 8'h01);
        $display("test sync done");
        tally_and_finish();
    end
endmodule

// >>> dnc_edge_det.sv
// Purpose: Rising edge detector for the SYSREF level
// Assumes: Input already synchronous to core_clk
// Notes: One-cycle pulse on each 0 to 1 transition
`timescale 1ns/1ps

module dnc_edge_det
    import dnc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic level_in,
    output logic rise_pulse
);

    logic prev_q;
    logic prev_d;

    // Next value of the delayed level
    always_comb begin
        prev_d = level_in;
    end

    // Delay by one cycle to find the edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // Prev resets to the idle low level; a level already high at release gives one pulse,
    // which is harmless because the arm state always leaves reset idle
    assign rise_pulse = level_in & ~prev_q;

endmodule

// >>> dnc_link_peer.sv
// Purpose: SYSREF source and link receiver stand-in
// Assumes: Bench requests each pulse
// Notes: SYSREF stays quiet unless asked, as alignment needs a silent source
`timescale 1ns/1ps
module dnc_link_peer(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sref_go,
    input wire logic [3:0] sref_len,
    input wire logic ila_go,
    output logic sysref,
    output logic lmfc_ila_start
);
    logic [3:0] cnt_q;
    // Pulse width counter, long pulses test a single edge only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            lmfc_ila_start <= 1'b0;
        end else begin
            cnt_q <= sref_go ? sref_len : (cnt_q != 4'h0 ? cnt_q - 4'h1 : cnt_q);
            lmfc_ila_start <= ila_go;
        end
    end
    assign sysref = (cnt_q != 4'h0);
endmodule

// >>> dnc_pkg.sv
// Purpose: Types for the channel binding and oscillator sync control block
// Assumes: Included constants header supplies the widths
// Notes: Types only, no logic
`include "dnc_consts.svh"

package dnc_pkg;

    // Register port request from software
    typedef struct packed {
        logic [`DNC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dnc_req_type;

    // Per-channel power state seen by the data path
    typedef struct packed {
        logic chan_a_pd;
        logic chan_b_pd;
    } dnc_pd_type;

    // Arm state of the SYSREF-triggered phase init
    typedef enum logic [1:0] {
        DNC_IDLE,
        DNC_ZERO_SEEN,
        DNC_ARMED
    } dnc_arm_type;

endpackage
